// *** include/dbw_pkg.sv ***
package dbw_pkg;
    localparam int NCMP = 4;
    localparam int NTHR = 8;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_IB_ADDR  = 8'h30;
    localparam logic [7:0] IDX_IB_CTL   = 8'h40;
    localparam logic [7:0] IDX_DW_ADDR1 = 8'h50;
    localparam logic [7:0] IDX_DW_ADDR2 = 8'h60;
    localparam logic [7:0] IDX_DW_CTL   = 8'h70;
    localparam logic [7:0] IDX_RW_MASK  = 8'h80;
    localparam logic [7:0] IDX_RW_VALUE = 8'h90;
    localparam logic [7:0] IDX_RW_CTL   = 8'h9C;
    localparam logic [7:0] IDX_EVT_STAT = 8'hA0;
    localparam logic [7:0] IDX_EVT_MASK = 8'hA1;
    localparam logic [7:0] IDX_CAUSE    = 8'hA2;
    localparam logic [7:0] IDX_DATA     = 8'hA3;
    // Control field positions
    localparam int CTL_ARM   = 0;
    localparam int CTL_SEL   = 1;
    localparam int CTL_LOADS = 2;
    localparam int CTL_THR_LO = 16;
    localparam logic [31:0] IB_CTL_WMASK = 32'h00FF_0003;
    localparam logic [31:0] DW_CTL_WMASK = 32'h00FF_0007;
    localparam logic [31:0] RW_CTL_WMASK = 32'h00FF_0003;
    // Cause codes and layout
    localparam logic [2:0] CAUSE_IBREAK = 3'h3;
    localparam logic [2:0] CAUSE_DWATCH = 3'h4;
    localparam logic [2:0] CAUSE_RWATCH = 3'h5;
    localparam int CAUSE_THR_LO = 8;
    localparam int CAUSE_NUM_LO = 16;
    // Event status bit positions
    localparam int EV_IB = 0;
    localparam int EV_DW = 1;
    localparam int EV_RW = 2;

    typedef struct packed {
        logic        valid;
        logic [2:0]  thread;
        logic [31:0] pc;
    } dbw_fetch_t;

    typedef struct packed {
        logic        valid;
        logic        store;
        logic [2:0]  thread;
        logic [31:0] addr;
    } dbw_mem_t;

    typedef struct packed {
        logic        valid;
        logic [2:0]  thread;
        logic [31:0] id;
    } dbw_res_t;

    typedef struct packed {
        logic [7:0]  idx;
        logic        write;
        logic [31:0] wdata;
    } dbw_bus_t;
endpackage

// *** hw/dbw_unit.sv ***
// Design decision made here: register access over APB.
`timescale 1ns/100ps
module dbw_unit (
    input  wire  logic                i_clock,
    input  wire  logic                i_nrst,
    input  wire  logic [11:0]         i_paddr,
    input  wire  logic                i_psel,
    input  wire  logic                i_penable,
    input  wire  logic                i_pwrite,
    input  wire  logic [31:0]         i_pwdata,
    output logic [31:0]               o_prdata,
    output logic                      o_pready,
    output logic                      o_pslverr,
    input  wire  dbw_pkg::dbw_fetch_t i_fetch,
    input  wire  dbw_pkg::dbw_mem_t   i_mem,
    input  wire  dbw_pkg::dbw_res_t   i_res,
    output logic                      o_debug_req,
    output logic                      o_irq
);
    import dbw_pkg::*;

    typedef struct packed {
        logic [NCMP-1:0][31:0] ib_addr;
        logic [NCMP-1:0][31:0] ib_ctl;
        logic [NCMP-1:0][31:0] dw_addr1;
        logic [NCMP-1:0][31:0] dw_addr2;
        logic [NCMP-1:0][31:0] dw_ctl;
        logic [NCMP-1:0][31:0] rw_mask;
        logic [NCMP-1:0][31:0] rw_value;
        logic [NCMP-1:0][31:0] rw_ctl;
        logic [2:0]            evt_stat;
        logic [2:0]            evt_mask;
        logic [31:0]           cause;
        logic [31:0]           data;
        logic [31:0]           prdata;
        logic                  pready;
        logic                  pslverr;
        logic                  debug_req;
        logic                  irq;
    } dbw_state_t;

    dbw_state_t st;
    dbw_state_t next_st;

    logic [NCMP-1:0] ib_hit;
    logic [NCMP-1:0] dw_hit;
    logic [NCMP-1:0] rw_hit;

    // Comparators, one per entry
    genvar g;
    generate
        for (g = 0; g < NCMP; g++) begin : g_cmp
            logic ib_eq;
            logic dw_a;
            logic dw_b;
            logic dw_cond;
            logic dw_kind;
            logic rw_a;
            assign ib_eq = (i_fetch.pc == st.ib_addr[g]);
            assign ib_hit[g] = i_fetch.valid && st.ib_ctl[g][CTL_ARM]
                && st.ib_ctl[g][CTL_THR_LO + i_fetch.thread]
                && (st.ib_ctl[g][CTL_SEL] ? !ib_eq : ib_eq);
            assign dw_a = (i_mem.addr >= st.dw_addr1[g]);
            assign dw_b = (i_mem.addr <= st.dw_addr2[g]);
            assign dw_cond = st.dw_ctl[g][CTL_SEL] ? (dw_a || dw_b) : (dw_a && dw_b);
            // Stores always qualify; loads only when asked for
            assign dw_kind = i_mem.store || st.dw_ctl[g][CTL_LOADS];
            assign dw_hit[g] = i_mem.valid && st.dw_ctl[g][CTL_ARM]
                && st.dw_ctl[g][CTL_THR_LO + i_mem.thread]
                && dw_kind && dw_cond;
            assign rw_a = ((i_res.id & st.rw_mask[g]) == (st.rw_value[g] & st.rw_mask[g]));
            assign rw_hit[g] = i_res.valid && st.rw_ctl[g][CTL_ARM]
                && st.rw_ctl[g][CTL_THR_LO + i_res.thread]
                && (st.rw_ctl[g][CTL_SEL] ? !rw_a : rw_a);
        end
    endgenerate

    // Lowest set bit index; caller ensures a bit is set
    function automatic logic [1:0] lowest(input logic [NCMP-1:0] v);
        logic [1:0] n;
        n = 2'h0;
        for (int k = NCMP - 1; k >= 0; k--) begin
            if (v[k]) begin
                n = k[1:0];
            end
        end
        return n;
    endfunction

    dbw_bus_t   bus;
    logic       in_range;
    logic [1:0] sel;
    logic [5:0] grp;
    logic       access;
    logic       wr;

    // One driver for the whole bus struct
    assign bus       = '{idx: i_paddr[9:2], write: i_pwrite, wdata: i_pwdata};
    assign sel       = bus.idx[1:0];
    assign grp       = bus.idx[7:2];
    // Unaligned or above the map counts as unmapped
    assign in_range  = (i_paddr[11:10] == 2'h0) && (i_paddr[1:0] == 2'h0);
    assign access    = i_psel && i_penable && st.pready;
    assign wr        = access && bus.write && !st.pslverr;

    always_comb begin
        logic [31:0] rd;
        logic        hit_map;
        logic [2:0]  evt;
        rd      = 32'h0000_0000;
        hit_map = in_range;
        evt     = 3'h0;
        next_st = st;

        // Read decode
        if (grp == IDX_IB_ADDR[7:2]) begin
            rd = st.ib_addr[sel];
        end else if (grp == IDX_IB_CTL[7:2]) begin
            rd = st.ib_ctl[sel];
        end else if (grp == IDX_DW_ADDR1[7:2]) begin
            rd = st.dw_addr1[sel];
        end else if (grp == IDX_DW_ADDR2[7:2]) begin
            rd = st.dw_addr2[sel];
        end else if (grp == IDX_DW_CTL[7:2]) begin
            rd = st.dw_ctl[sel];
        end else if (grp == IDX_RW_MASK[7:2]) begin
            rd = st.rw_mask[sel];
        end else if (grp == IDX_RW_VALUE[7:2]) begin
            rd = st.rw_value[sel];
        end else if (grp == IDX_RW_CTL[7:2]) begin
            rd = st.rw_ctl[sel];
        end else if (bus.idx == IDX_EVT_STAT) begin
            rd = {29'h0, st.evt_stat};
        end else if (bus.idx == IDX_EVT_MASK) begin
            rd = {29'h0, st.evt_mask};
        end else if (bus.idx == IDX_CAUSE) begin
            rd = st.cause;
        end else if (bus.idx == IDX_DATA) begin
            rd = st.data;
        end else begin
            hit_map = 1'b0;
        end

        // Registered ready gives one access cycle, no waits
        next_st.pready = i_psel && !i_penable;
        if (i_psel && !i_penable) begin
            next_st.pslverr = !hit_map;
            next_st.prdata  = (hit_map && !bus.write) ? rd : 32'h0000_0000;
        end else if (access) begin
            next_st.pslverr = 1'b0;
        end

        // Writes land at the access edge only
        if (wr) begin
            if (grp == IDX_IB_ADDR[7:2]) begin
                next_st.ib_addr[sel] = bus.wdata;
            end else if (grp == IDX_IB_CTL[7:2]) begin
                next_st.ib_ctl[sel] = bus.wdata & IB_CTL_WMASK;
            end else if (grp == IDX_DW_ADDR1[7:2]) begin
                next_st.dw_addr1[sel] = bus.wdata;
            end else if (grp == IDX_DW_ADDR2[7:2]) begin
                next_st.dw_addr2[sel] = bus.wdata;
            end else if (grp == IDX_DW_CTL[7:2]) begin
                next_st.dw_ctl[sel] = bus.wdata & DW_CTL_WMASK;
            end else if (grp == IDX_RW_MASK[7:2]) begin
                next_st.rw_mask[sel] = bus.wdata;
            end else if (grp == IDX_RW_VALUE[7:2]) begin
                next_st.rw_value[sel] = bus.wdata;
            end else if (grp == IDX_RW_CTL[7:2]) begin
                next_st.rw_ctl[sel] = bus.wdata & RW_CTL_WMASK;
            end else if (bus.idx == IDX_EVT_STAT) begin
                next_st.evt_stat = st.evt_stat & ~bus.wdata[2:0];
            end else if (bus.idx == IDX_EVT_MASK) begin
                next_st.evt_mask = bus.wdata[2:0];
            end else if (bus.idx == IDX_CAUSE) begin
                next_st.cause = bus.wdata;
            end else if (bus.idx == IDX_DATA) begin
                next_st.data = bus.wdata;
            end
        end

        // Cause capture; fixed class order, lowest comparator within class
        if (|ib_hit) begin
            evt[EV_IB] = 1'b1;
            next_st.cause = 32'h0000_0000;
            next_st.cause[2:0] = CAUSE_IBREAK;
            next_st.cause[CAUSE_NUM_LO +: 2] = lowest(ib_hit);
            next_st.cause[CAUSE_THR_LO +: 3] = i_fetch.thread;
        end else if (|dw_hit) begin
            evt[EV_DW] = 1'b1;
            next_st.cause = 32'h0000_0000;
            next_st.cause[2:0] = CAUSE_DWATCH;
            next_st.cause[CAUSE_NUM_LO +: 2] = lowest(dw_hit);
            next_st.cause[CAUSE_THR_LO +: 3] = i_mem.thread;
            next_st.data = i_mem.addr;
        end else if (|rw_hit) begin
            evt[EV_RW] = 1'b1;
            next_st.cause = 32'h0000_0000;
            next_st.cause[2:0] = CAUSE_RWATCH;
            next_st.cause[CAUSE_NUM_LO +: 2] = lowest(rw_hit);
            next_st.cause[CAUSE_THR_LO +: 3] = i_res.thread;
            next_st.data = i_res.id;
        end
        // Later classes still flag status so no event is lost
        if (|dw_hit) begin
            evt[EV_DW] = 1'b1;
        end
        if (|rw_hit) begin
            evt[EV_RW] = 1'b1;
        end

        // Set wins over a same-cycle clear
        next_st.evt_stat  = next_st.evt_stat | evt;
        next_st.debug_req = |evt;
        next_st.irq       = |(next_st.evt_stat & next_st.evt_mask);
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_prdata    = st.prdata;
    assign o_pready    = st.pready;
    assign o_pslverr   = st.pslverr;
    assign o_debug_req = st.debug_req;
    assign o_irq       = st.irq;
endmodule // dbw_unit

// *** test/dbw_unit_sva.sv ***
`timescale 1ns/100ps
module dbw_unit_sva (
    input wire logic                i_clock,
    input wire logic                i_nrst,
    input wire logic [11:0]         i_paddr,
    input wire logic                i_psel,
    input wire logic                i_penable,
    input wire logic                i_pwrite,
    input wire logic [31:0]         i_pwdata,
    input wire logic [31:0]         o_prdata,
    input wire logic                o_pready,
    input wire logic                o_pslverr,
    input wire dbw_pkg::dbw_fetch_t i_fetch,
    input wire dbw_pkg::dbw_mem_t   i_mem,
    input wire dbw_pkg::dbw_res_t   i_res,
    input wire logic                o_debug_req,
    input wire logic                o_irq
);
    import dbw_pkg::*;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    AST_READY_AFTER_SETUP: assert property (i_psel && !i_penable |=> o_pready) else $error("no ready after setup");
    AST_READY_SINGLE: assert property (o_pready |=> !o_pready) else $error("ready held two cycles");
    AST_ERR_WITH_READY: assert property (o_pslverr |-> o_pready) else $error("slverr without ready");
    AST_ERR_LOW_BITS: assert property (i_psel && !i_penable && i_paddr[1:0] != 2'h0 ##1 o_pready |-> o_pslverr)
        else $error("misaligned access accepted");
    AST_ERR_HIGH_BITS: assert property (i_psel && !i_penable && i_paddr[11:10] != 2'h0 |=> o_pslverr)
        else $error("out of range access accepted");
    AST_WRITE_ZERO_DATA: assert property (o_pready && i_pwrite |-> o_prdata == 32'h0) else $error("data on write");
    AST_ERR_READ_ZERO: assert property (o_pslverr |-> o_prdata == 32'h0) else $error("data on error");
    AST_QUIET_NO_STREAM: assert property (!i_fetch.valid && !i_mem.valid && !i_res.valid |=> !o_debug_req)
        else $error("debug request without access");
    AST_RESET_RELEASE_QUIET: assert property ($rose(i_nrst) |-> !o_irq && !o_debug_req && !o_pready)
        else $error("outputs active out of reset");
    COV_HIT: cover property (i_fetch.valid ##1 o_debug_req);
    COV_IRQ: cover property ($rose(o_irq));
    COV_ERR: cover property (o_pslverr);
endmodule // dbw_unit_sva

bind dbw_unit dbw_unit_sva sva_u (.i_clock(i_clock), .i_nrst(i_nrst), .i_paddr(i_paddr), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_fetch(i_fetch), .i_mem(i_mem), .i_res(i_res), .o_debug_req(o_debug_req),
    .o_irq(o_irq));

// *** test/dbw_core_model.sv ***
`timescale 1ns/100ps
// Idle payloads are inverted so a stale value never matches by chance
module dbw_core_model (
    input  wire  dbw_pkg::dbw_fetch_t i_fetch_cmd,
    input  wire  dbw_pkg::dbw_mem_t   i_mem_cmd,
    input  wire  dbw_pkg::dbw_res_t   i_res_cmd,
    output dbw_pkg::dbw_fetch_t       o_fetch,
    output dbw_pkg::dbw_mem_t         o_mem,
    output dbw_pkg::dbw_res_t         o_res
);
    import dbw_pkg::*;
    assign o_fetch = i_fetch_cmd.valid ? i_fetch_cmd : {1'b0, ~i_fetch_cmd[34:0]};
    assign o_mem   = i_mem_cmd.valid ? i_mem_cmd : {1'b0, ~i_mem_cmd[35:0]};
    assign o_res   = i_res_cmd.valid ? i_res_cmd : {1'b0, ~i_res_cmd[34:0]};
endmodule // dbw_core_model

// *** test/test_dbw_unit.sv ***
`timescale 1ns/100ps
module test_dbw_unit;
    import dbw_pkg::*;
    logic        i_clock, i_nrst, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_debug_req, o_irq, err;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, rd, seed, pcv;
    dbw_fetch_t  f, i_fetch;
    dbw_mem_t    m, i_mem;
    dbw_res_t    r, i_res;
    int          fails, n_checks;
    logic [7:0]  bases [8] = '{IDX_IB_ADDR, IDX_DW_ADDR1, IDX_DW_ADDR2, IDX_RW_MASK, IDX_RW_VALUE,
                               IDX_IB_CTL, IDX_DW_CTL, IDX_RW_CTL};
    logic [31:0] wm [8] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
                            IB_CTL_WMASK, DW_CTL_WMASK, RW_CTL_WMASK};
    dbw_unit dut_u (.i_clock(i_clock), .i_nrst(i_nrst), .i_paddr(i_paddr), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_fetch(i_fetch), .i_mem(i_mem), .i_res(i_res), .o_debug_req(o_debug_req), .o_irq(o_irq));
    dbw_core_model core_u (.i_fetch_cmd(f), .i_mem_cmd(m), .i_res_cmd(r), .o_fetch(i_fetch), .o_mem(i_mem),
        .o_res(i_res));
    function logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function logic [31:0] cz(input logic [31:0] num, thr, code);
        return (num << CAUSE_NUM_LO) | (thr << CAUSE_THR_LO) | code;
    endfunction
    task test_done;
        if (fails == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, s);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Holds the request until ready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clock);
        i_penable <= 1'b1;
        do @(posedge i_clock); while (o_pready !== 1'b1);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task wr(input logic [7:0] idx, input logic [31:0] d);
        apb(1'b1, {2'h0, idx, 2'h0}, d);
    endtask
    task rdc(input string nm, input logic [7:0] idx, input logic [31:0] e);
        apb(1'b0, {2'h0, idx, 2'h0}, 32'h0);
        chk(nm, e, rd);
    endtask
    // One access cycle; zero cause means no hit expected
    task fire(input dbw_fetch_t ff, input dbw_mem_t mm, input dbw_res_t rr, input logic [31:0] ec);
        @(posedge i_clock);
        f <= ff;
        m <= mm;
        r <= rr;
        @(posedge i_clock);
        f.valid <= 1'b0;
        m.valid <= 1'b0;
        r.valid <= 1'b0;
        #1;
        chk("debug_req", {31'h0, ec != 32'h0}, {31'h0, o_debug_req});
        if (ec != 32'h0) rdc("cause", IDX_CAUSE, ec);
    endtask
    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end
    initial begin
        repeat (20000) @(posedge i_clock);
        fails++;
        test_done;
    end
    initial begin
        {i_nrst, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, f, m, r} = '0;
        {fails, n_checks} = '0;
        seed = 32'h1F;
        repeat (3) @(posedge i_clock);
        i_nrst <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            rdc("ib_ctl", IDX_IB_CTL + 8'(k), 32'h0);
            rdc("dw_ctl", IDX_DW_CTL + 8'(k), 32'h0);
            rdc("rw_ctl", IDX_RW_CTL + 8'(k), 32'h0);
        end
        for (int b = 0; b < 8; b++) for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            wr(bases[b] + 8'(k), seed);
            rdc("reg", bases[b] + 8'(k), seed & wm[b]);
            if (b >= 5) wr(bases[b] + 8'(k), 32'h0);
        end
        apb(1'b0, 12'h300, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        apb(1'b1, 12'h802, 32'h0);
        chk("bad_addr", 32'h1, {31'h0, err});
        pcv = lfsr(seed);
        wr(IDX_EVT_MASK, 32'h1);
        wr(IDX_IB_ADDR, pcv);
        wr(IDX_IB_ADDR + 8'h1, pcv);
        wr(IDX_IB_CTL, 32'h0001_0001);
        wr(IDX_IB_CTL + 8'h1, 32'h0002_0001);
        fire('{1'b1, 3'h2, pcv}, '0, '0, 32'h0);
        fire('{1'b1, 3'h0, pcv}, '0, '0, cz(0, 0, CAUSE_IBREAK));
        chk("irq", 32'h1, {31'h0, o_irq});
        wr(IDX_IB_CTL, 32'h0002_0001);
        fire('{1'b1, 3'h1, pcv}, '0, '0, cz(0, 1, CAUSE_IBREAK));
        wr(IDX_IB_CTL + 8'h1, 32'h0);
        wr(IDX_IB_CTL, 32'h0002_0003);
        fire('{1'b1, 3'h1, pcv}, '0, '0, 32'h0);
        fire('{1'b1, 3'h1, pcv ^ 32'h4}, '0, '0, cz(0, 1, CAUSE_IBREAK));
        wr(IDX_IB_CTL, 32'h0);
        wr(IDX_EVT_STAT, 32'h1);
        rdc("status", IDX_EVT_STAT, 32'h0);
        chk("irq", 32'h0, {31'h0, o_irq});
        wr(IDX_DW_ADDR1 + 8'h2, 32'h0000_0100);
        wr(IDX_DW_ADDR2 + 8'h2, 32'h0000_0200);
        wr(IDX_DW_CTL + 8'h2, 32'h0001_0001);
        fire('0, '{1'b1, 1'b1, 3'h0, 32'h180}, '0, cz(2, 0, CAUSE_DWATCH));
        rdc("data", IDX_DATA, 32'h180);
        fire('0, '{1'b1, 1'b0, 3'h0, 32'h180}, '0, 32'h0);
        fire('0, '{1'b1, 1'b1, 3'h1, 32'h180}, '0, 32'h0);
        fire('0, '{1'b1, 1'b1, 3'h0, 32'h280}, '0, 32'h0);
        wr(IDX_DW_CTL + 8'h2, 32'h0001_0007);
        fire('0, '{1'b1, 1'b0, 3'h0, 32'h280}, '0, cz(2, 0, CAUSE_DWATCH));
        wr(IDX_DW_CTL + 8'h2, 32'h0);
        wr(IDX_RW_MASK + 8'h3, 32'h0000_FF00);
        wr(IDX_RW_VALUE + 8'h3, 32'h1234_5600);
        wr(IDX_RW_CTL + 8'h3, 32'h0001_0001);
        fire('0, '0, '{1'b1, 3'h0, 32'hABCD_56EF}, cz(3, 0, CAUSE_RWATCH));
        rdc("data", IDX_DATA, 32'hABCD_56EF);
        fire('0, '0, '{1'b1, 3'h0, 32'h0000_5700}, 32'h0);
        wr(IDX_RW_CTL + 8'h3, 32'h0001_0003);
        fire('0, '0, '{1'b1, 3'h0, 32'h0000_5700}, cz(3, 0, CAUSE_RWATCH));
        rdc("status", IDX_EVT_STAT, 32'h6);
        test_done;
    end
endmodule // test_dbw_unit
